// ---- dv/ifqd_fetch_decode_assertions.sv ----
// Port-level checks on the fetch queue and decoder.
// Assumes one core_clk domain and a synchronous active-low reset.
`timescale 1ns/1ps
module ifqd_fetch_decode_assertions
  import ifqd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic prog_read_req,
  input wire logic prog_read_ready,
  input wire logic [PADDR_W-1:0] program_read_address_bus,
  input wire logic branch_taken,
  input wire logic [PADDR_W-1:0] branch_target,
  input wire logic cond_pending,
  input wire logic dec_valid,
  input wire logic [2:0] dec_len,
  input wire logic [7:0] dec_opcode,
  input wire logic dec_parallel,
  input wire logic dec_illegal,
  input wire logic absolute_23bit_address_mode,
  input wire logic [15:0] imm_const,
  input wire logic store_imm_valid,
  input wire logic [15:0] store_imm_data,
  input wire logic spec_fetch,
  input wire logic [QPTR_W-1:0] queue_fill
);
  logic started;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Fetch may only start once a first branch has given it a target
  always_ff @(posedge core_clk) begin
    if (!rst_n) started <= 1'b0;
    else if (branch_taken) started <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Fetch side
  // ----------------------------------------------------------------
  sequence s_taken;
    prog_read_req && prog_read_ready && !branch_taken;
  endsequence
  sequence s_spec;
    prog_read_req && prog_read_ready && cond_pending;
  endsequence

  property p_idle; !started |-> !prog_read_req; endproperty
  a_idle: assert property (p_idle) else $error("fetch before branch");
  property p_step;
    s_taken ##1 (prog_read_req && !branch_taken) |->
      program_read_address_bus == $past(program_read_address_bus) + 24'h4;
  endproperty
  a_step: assert property (p_step) else $error("fetch not +4");
  property p_target;
    branch_taken ##1 prog_read_req |->
      program_read_address_bus == ($past(branch_target) & 24'hfffffc);
  endproperty
  a_target: assert property (p_target) else $error("bad target");
  property p_flush; branch_taken |=> queue_fill == 7'h0; endproperty
  a_flush: assert property (p_flush) else $error("queue kept");
  property p_cap; queue_fill <= 7'h40; endproperty
  a_cap: assert property (p_cap) else $error("queue over 64");
  property p_room; prog_read_req |-> queue_fill <= 7'h3c; endproperty
  a_room: assert property (p_room) else $error("fetch without room");
  property p_spec; s_spec |=> spec_fetch; endproperty
  a_spec: assert property (p_spec) else $error("no spec mark");

  // ----------------------------------------------------------------
  // Decode side
  // ----------------------------------------------------------------
  property p_ext;
    dec_valid && absolute_23bit_address_mode |->
      dec_len == 3'h7 && dec_opcode[7:5] == 3'h3;
  endproperty
  a_ext: assert property (p_ext) else $error("bad extended form");
  property p_len;
    dec_valid && !absolute_23bit_address_mode && !dec_illegal |->
      dec_len == dec_opcode[7:5] + 3'h1;
  endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_par; dec_parallel |-> dec_valid && dec_opcode[4]; endproperty
  a_par: assert property (p_par) else $error("bad pair flag");
  property p_illegal;
    dec_illegal |-> dec_valid && dec_len == 3'h1 && dec_opcode[7:6] == 2'b11
      && !store_imm_valid && !absolute_23bit_address_mode;
  endproperty
  a_illegal: assert property (p_illegal) else $error("bad illegal");
  property p_store;
    store_imm_valid |->
      dec_valid && !dec_illegal && store_imm_data == imm_const;
  endproperty
  a_store: assert property (p_store) else $error("bad store data");
endmodule

bind ifqd_fetch_decode ifqd_fetch_decode_assertions u_chk (
  .core_clk, .rst_n, .prog_read_req, .prog_read_ready,
  .program_read_address_bus, .branch_taken, .branch_target, .cond_pending,
  .dec_valid, .dec_len, .dec_opcode, .dec_parallel, .dec_illegal,
  .absolute_23bit_address_mode, .imm_const, .store_imm_valid,
  .store_imm_data, .spec_fetch, .queue_fill
);

// ---- dv/ifqd_prog_mem.sv ----
// Program memory model that answers the fetches of the instruction queue.
// Assumes requests are presented after a core_clk edge and held until taken.
`timescale 1ns/1ps
module ifqd_prog_mem
  import ifqd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic slow,
  input wire logic prog_read_req,
  input wire logic [PADDR_W-1:0] program_read_address_bus,
  output logic prog_read_ready,
  output logic prog_read_valid,
  output logic [PDATA_W-1:0] program_read_data_bus
);
  logic [PADDR_W-1:0] pend[$];
  logic [PADDR_W-1:0] a;

  // Code image hashed from the address; a few illegal lengths occur
  function automatic logic [7:0] mb(input logic [23:0] x);
    logic [7:0] h;
    h = (x[7:0] * 8'h1d) ^ x[15:8];
    return (h[7:6] == 2'b11 && x[2:0] != 3'h0) ? (h ^ 8'h40) : h;
  endfunction

  // Stall comes from the bench so the queue sees slow grants
  assign prog_read_ready = !stall;

  // In-order answers; idle data flips so stale bytes never look valid
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pend.delete();
      prog_read_valid <= 1'b0;
      program_read_data_bus <= 32'h0;
    end else begin
      if (prog_read_req && prog_read_ready) begin
        pend.push_back(program_read_address_bus);
      end
      if (pend.size() > 0 && !slow) begin
        a = pend.pop_front();
        prog_read_valid <= 1'b1;
        program_read_data_bus <= {mb(a + 24'h3), mb(a + 24'h2),
                                  mb(a + 24'h1), mb(a)};
      end else begin
        prog_read_valid <= 1'b0;
        program_read_data_bus <= ~program_read_data_bus;
      end
    end
  end
endmodule

// ---- dv/test_instruction_fetch_queue_decoder.sv ----
// Self-checking bench: random fetch and decode traffic with branches.
// Assumes the memory model of this folder and a 10 MHz core_clk.
`timescale 1ns/1ps
module test_instruction_fetch_queue_decoder;
  import ifqd_pkg::*;
  logic core_clk, rst_n, prog_read_req, prog_read_ready, prog_read_valid;
  logic branch_taken, cond_pending, dec_ready, dec_valid, dec_parallel;
  logic dec_illegal, flow_cmd_valid, addr_cmd_valid, comp_cmd_valid;
  logic absolute_23bit_address_mode, store_imm_valid, spec_fetch;
  logic stall, slow, rnd_on, loop_begin, loop_again, loop_end;
  logic [23:0] program_read_address_bus, branch_target, pc, loop_pc;
  logic [31:0] program_read_data_bus;
  logic [2:0] dec_len;
  logic [7:0] dec_opcode;
  logic [47:0] dec_operands;
  logic [15:0] imm_const, store_imm_data, seed;
  logic [22:0] abs_operand_addr;
  logic [6:0] queue_fill;
  logic [23:0] tgt[4] = '{24'h000103, 24'hfffffd, 24'h000000, 24'h7a52c1};
  int fail_count, total_checks, ext_seen, cycles;

  ifqd_fetch_decode dut (.core_clk, .rst_n, .prog_read_req,
    .prog_read_ready, .program_read_address_bus, .prog_read_valid,
    .program_read_data_bus, .branch_taken, .branch_target, .cond_pending,
    .loop_begin, .loop_again, .loop_end, .dec_ready,
    .dec_valid, .dec_len, .dec_opcode, .dec_operands, .dec_parallel,
    .dec_illegal, .flow_cmd_valid, .addr_cmd_valid, .comp_cmd_valid,
    .imm_const, .absolute_23bit_address_mode, .abs_operand_addr,
    .store_imm_valid, .store_imm_data, .spec_fetch, .queue_fill);
  ifqd_prog_mem mem (.core_clk, .rst_n, .stall, .slow, .prog_read_req,
    .program_read_address_bus, .prog_read_ready, .prog_read_valid,
    .program_read_data_bus);

  // Same code image as the memory model, kept apart on purpose
  function automatic logic [7:0] mb(input logic [23:0] x);
    logic [7:0] h;
    h = (x[7:0] * 8'h1d) ^ x[15:8];
    return (h[7:6] == 2'b11 && x[2:0] != 3'h0) ? (h ^ 8'h40) : h;
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t at %h got %h exp %h", $time, pc, got, exp);
    end
  endtask

  // Works out the instruction at pc and compares every field
  task automatic check_instr();
    logic [7:0] bt[7];
    logic ext, ill, st;
    logic [2:0] n, u;
    logic [15:0] imm;
    for (int i = 0; i < 7; i++) bt[i] = mb(pc + 24'(i));
    ill = bt[0][7:6] == 2'b11;
    ext = bt[0][7:5] == 3'h3 && bt[1][7:4] <= 4'hd && bt[2][7];
    n = ill ? 3'h1 : ext ? 3'h7 : bt[0][7:5] + 3'h1;
    imm = ext ? {bt[4], bt[3]} : {bt[2], bt[1]};
    u = (ill || bt[0][3:2] == 2'h3) ? 3'h0 : 3'b100 >> bt[0][3:2];
    st = !ill && (bt[0][3:2] == 2'h3
      || (bt[0][7:5] == 3'h3 && bt[1][7:4] == 4'hd));
    ext_seen += int'(ext);
    cmp(48'(dec_opcode), 48'(bt[0]));
    cmp(48'(dec_len), 48'(n));
    cmp(48'(dec_parallel), 48'(bt[0][4]));
    cmp(48'(absolute_23bit_address_mode), 48'(ext));
    cmp(48'(dec_illegal), 48'(ill));
    for (int i = 0; i < n - 1; i++)
      cmp(48'(dec_operands[8*i+:8]), 48'(bt[i+1]));
    if (n >= 3) cmp(48'(imm_const), 48'(imm));
    if (ext)
      cmp(48'(abs_operand_addr), 48'({bt[6][6:0], bt[5], bt[4]}));
    cmp(48'({flow_cmd_valid, addr_cmd_valid, comp_cmd_valid}),
        48'(u));
    cmp(48'(store_imm_valid), 48'(st));
    if (st && n >= 3) cmp(48'(store_imm_data), 48'(imm));
    pc = pc + 24'(n);
  endtask

  task automatic branch_to(input logic [23:0] t);
    @(posedge core_clk);
    branch_taken <= 1'b1;
    branch_target <= t;
    @(posedge core_clk);
    branch_taken <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always #50 core_clk = ~core_clk;

  // Decode stream follows the old pc until a branch is sampled
  always @(posedge core_clk) begin
    if (rst_n && dec_valid === 1'b1) check_instr();
    if (rst_n && branch_taken) pc = branch_target;
    if (rst_n && loop_begin) loop_pc = pc;
    if (rst_n && loop_again) pc = loop_pc;
  end

  // Random handshakes from the shift register; run cut short on a hang
  always @(posedge core_clk) begin
    cycles++;
    if (rnd_on) begin
      seed <= lfsr(seed);
      dec_ready <= seed[0] | seed[1];
      stall <= seed[2] & seed[3];
      slow <= seed[4];
      cond_pending <= seed[5];
    end
    if (cycles == 4000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    core_clk = 0; rst_n = 0; branch_taken = 0; branch_target = '0;
    cond_pending = 0; dec_ready = 0; stall = 0; slow = 0; rnd_on = 0;
    seed = 16'h000c; pc = '0; loop_pc = '0;
    loop_begin = 0; loop_again = 0; loop_end = 0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    cmp(48'({prog_read_req, dec_valid, queue_fill}), 48'h0);
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    cmp(48'(prog_read_req), 48'h0);
    $display("reset test done");
    // Unaligned target, decode held: queue fills until refused
    branch_to(24'h00004a);
    repeat (40) @(posedge core_clk);
    @(negedge core_clk);
    cmp(48'(queue_fill), 48'(QUEUE_LIMIT - 8'h2));
    cmp(48'(prog_read_req), 48'h0);
    $display("fill test done");
    rnd_on = 1;
    repeat (200) @(posedge core_clk);
    cmp(48'(ext_seen > 0), 48'h1);
    $display("extended test done");
    // Repeat block: mark, rewind twice from the queue, release
    @(posedge core_clk);
    loop_begin <= 1'b1;
    @(posedge core_clk);
    loop_begin <= 1'b0;
    repeat (2) begin
      repeat (6) @(posedge core_clk);
      loop_again <= 1'b1;
      @(posedge core_clk);
      loop_again <= 1'b0;
    end
    loop_end <= 1'b1;
    @(posedge core_clk);
    loop_end <= 1'b0;
    repeat (20) @(posedge core_clk);
    $display("repeat test done");
    // Two branches one idle cycle apart, then a table of targets
    branch_to(24'h000201);
    branch_to(24'h00004a);
    repeat (200) @(posedge core_clk);
    foreach (tgt[i]) begin
      branch_to(tgt[i]);
      repeat (250) @(posedge core_clk);
    end
    $display("branch test done");
    conclude();
  end
endmodule

// ---- verilog/ifqd_byte_ram.sv ----
// Byte store of the instruction queue: word writes, 7-byte window reads.
// Assumes the owner keeps pointers in range; read data is registered.
`timescale 1ns/1ps
module ifqd_byte_ram
  import ifqd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [QADDR_W-3:0] wr_word,
  input wire logic [PDATA_W-1:0] wr_data,
  input wire logic [QADDR_W-1:0] rd_addr,
  output logic [8*WIN_BYTES-1:0] rd_window
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:QUEUE_BYTES-1];

  // Word write; one process owns the whole array
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      for (int lane = 0; lane < WORD_BYTES; lane++) begin
        mem[{wr_word, 2'(lane)}] <= wr_data[8*lane +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Window read with write forwarding
  // ----------------------------------------------------------------
  // Forwarding lets a word written this cycle be decoded next cycle
  genvar pos;
  generate
    for (pos = 0; pos < WIN_BYTES; pos++) begin : g_rd
      logic [QADDR_W-1:0] addr;
      logic hit;
      logic [7:0] byte_q;
      assign addr = rd_addr + QADDR_W'(pos);
      assign hit = wr_en && (addr[QADDR_W-1:2] == wr_word);
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          byte_q <= 8'h00;
        end else if (hit) begin
          byte_q <= wr_data[8*addr[1:0] +: 8];
        end else begin
          byte_q <= mem[addr];
        end
      end
      assign rd_window[8*pos +: 8] = byte_q;
    end
  endgenerate

endmodule

// ---- verilog/ifqd_fetch_decode.sv ----
// Program fetch queue and variable-length instruction decoder.
// Assumes an in-order program memory port on the same clock and
// execution units that pulse their flush and loop controls.
//
// Contract
// - Program code arrives as 32-bit words, four bytes per transfer.
// - Each fetch presents a 24-bit byte address on the address bus.
// - Accept four new bytes per cycle; decode one to seven queued bytes.
// - Queue never holds more than 64 bytes of undecoded code.
// - Decoder sees a seven-byte window of queued code.
// - A branch to a new location discards every queued byte.
// - Repeats keep their code loaded; queue need not be full.
// - Local repeat runs the block straight from the queue.
// - Fetching continues while a branch condition is still tested.
// - Find boundaries of 1 to 6 byte instructions.
// - Flag instruction pairs that execute in parallel.
// - Dispatch commands and extracted constants to each unit.
// - Immediate store values leave on a dedicated data path.
// - 4-byte opcode with 23-bit absolute operand decodes as 7 bytes.
// - Only the listed 4-byte instruction classes take the extension.
// - Fetch addresses advance sequentially; branches load targets.
`timescale 1ns/1ps
module ifqd_fetch_decode
  import ifqd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  output logic prog_read_req,
  input wire logic prog_read_ready,
  output logic [PADDR_W-1:0] program_read_address_bus,
  input wire logic prog_read_valid,
  input wire logic [PDATA_W-1:0] program_read_data_bus,
  input wire logic branch_taken,
  input wire logic [PADDR_W-1:0] branch_target,
  input wire logic cond_pending,
  input wire logic loop_begin,
  input wire logic loop_again,
  input wire logic loop_end,
  input wire logic dec_ready,
  output logic dec_valid,
  output logic [2:0] dec_len,
  output logic [7:0] dec_opcode,
  output logic [8*(WIN_BYTES-1)-1:0] dec_operands,
  output logic dec_parallel,
  output logic dec_illegal,
  output logic flow_cmd_valid,
  output logic addr_cmd_valid,
  output logic comp_cmd_valid,
  output logic [15:0] imm_const,
  output logic absolute_23bit_address_mode,
  output logic [ABS_ADDR_W-1:0] abs_operand_addr,
  output logic store_imm_valid,
  output logic [15:0] store_imm_data,
  output logic spec_fetch,
  output logic [QPTR_W-1:0] queue_fill
);

  // ----------------------------------------------------------------
  // Length decode
  // ----------------------------------------------------------------
  // True when the class byte names a 4-byte opcode that may extend
  function automatic logic ext_class(input logic [3:0] cls);
    ext_class = (cls <= CLS_LD_MEM_IMM);
  endfunction

  ifqd_fetch_t fetch_state;
  logic [PADDR_W-1:0] fetch_addr;
  logic [QPTR_W-1:0] wr_ptr;
  logic [QPTR_W-1:0] rd_ptr;
  logic [QPTR_W-1:0] loop_base;
  logic loop_active;
  logic [2:0] inflight;
  logic [2:0] drop_cnt;
  logic [8*WIN_BYTES-1:0] window;

  // ----------------------------------------------------------------
  // Window bytes and instruction fields
  // ----------------------------------------------------------------
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [2:0] len_code;
  logic code_ok;
  logic [2:0] base_len;
  logic is_ext;
  logic [2:0] need_len;
  logic [1:0] unit_sel;
  logic store_class;

  assign b0 = window[7:0];
  assign b1 = window[15:8];
  assign b2 = window[23:16];
  assign len_code = b0[OP_LEN_HI:OP_LEN_LO];
  // Codes above six bytes are illegal and consume a single byte
  assign code_ok = (len_code < LEN_MAX);
  assign base_len = code_ok ? len_code + LEN_MIN : LEN_MIN;
  assign is_ext = (base_len == LEN_EXTENDABLE)
    && ext_class(b1[CLS_HI:CLS_LO])
    && b2[ABS23_BIT];
  assign need_len = is_ext ? LEN_EXTENDED : base_len;
  assign unit_sel = b0[OP_UNIT_HI:OP_UNIT_LO];
  assign store_class = (unit_sel == UNIT_STORE)
    || ((base_len == LEN_EXTENDABLE)
      && (b1[CLS_HI:CLS_LO] == CLS_LD_MEM_IMM));

  // ----------------------------------------------------------------
  // Queue occupancy and flow control
  // ----------------------------------------------------------------
  logic [QPTR_W-1:0] fill_rd;
  logic [QPTR_W-1:0] fill_hold;
  logic [7:0] committed;
  logic room;
  logic run;
  logic issue;
  logic accept;
  logic consume;

  assign fill_rd = wr_ptr - rd_ptr;
  // During a repeat the block start is held, so space counts from it
  assign fill_hold = loop_active ? wr_ptr - loop_base : fill_rd;
  assign committed = 8'(fill_hold) + {3'h0, inflight, 2'h0} + WORD_SPAN;
  assign room = (committed <= QUEUE_LIMIT);
  assign run = (fetch_state == FETCH_RUN);
  // Condition tests do not gate fetch: it runs ahead speculatively
  assign prog_read_req = run && room && !branch_taken
    && (inflight < INFLIGHT_MAX);
  assign issue = prog_read_req && prog_read_ready;
  // Words still in flight at a branch are dropped on return
  assign accept = prog_read_valid && (drop_cnt == 3'h0)
    && !branch_taken;
  // Decode waits until the whole instruction is queued
  assign consume = dec_ready && !branch_taken && !loop_again
    && (fill_rd >= QPTR_W'(need_len));

  // ----------------------------------------------------------------
  // Next pointer values
  // ----------------------------------------------------------------
  logic [QPTR_W-1:0] next_rd_ptr;
  logic [QPTR_W-1:0] next_wr_ptr;
  logic [2:0] next_inflight;
  logic [2:0] next_drop_cnt;

  // Flush wins over repeat, repeat over decode
  assign next_rd_ptr = branch_taken ? QPTR_W'(branch_target[1:0])
    : loop_again ? loop_base
    : consume ? rd_ptr + QPTR_W'(need_len)
    : rd_ptr;
  // Writes land word aligned; an unaligned target skips low bytes
  assign next_wr_ptr = branch_taken ? QPTR_W'(branch_target[1:0])
    : accept ? {wr_ptr[QPTR_W-1:2] + 5'h01, 2'h0}
    : wr_ptr;
  assign next_inflight = inflight + (issue ? 3'h1 : 3'h0)
    - (prog_read_valid ? 3'h1 : 3'h0);
  assign next_drop_cnt = branch_taken
    ? inflight - (prog_read_valid ? 3'h1 : 3'h0)
    : drop_cnt - ((prog_read_valid && drop_cnt != 3'h0) ? 3'h1 : 3'h0);

  // ----------------------------------------------------------------
  // Byte store
  // ----------------------------------------------------------------
  ifqd_byte_ram u_ram (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(accept),
    .wr_word(wr_ptr[QADDR_W-1:2]),
    .wr_data(program_read_data_bus),
    .rd_addr(next_rd_ptr[QADDR_W-1:0]),
    .rd_window(window)
  );

  // ----------------------------------------------------------------
  // Fetch sequencer
  // ----------------------------------------------------------------
  // Idle after reset until the first branch supplies a start address
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fetch_state <= FETCH_IDLE;
    end else begin
      case (fetch_state)
        FETCH_IDLE: begin
          if (branch_taken) begin
            fetch_state <= FETCH_RUN;
          end
        end
        FETCH_RUN: begin
          fetch_state <= FETCH_RUN;
        end
        default: begin
          fetch_state <= FETCH_IDLE;
        end
      endcase
    end
  end

  // Fetch address: sequential words, reloaded on a branch
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fetch_addr <= '0;
    end else if (branch_taken) begin
      fetch_addr <= {branch_target[PADDR_W-1:2], 2'h0};
    end else if (issue) begin
      fetch_addr <= fetch_addr + PADDR_W'(WORD_BYTES);
    end
  end
  assign program_read_address_bus = fetch_addr;

  // Queue pointers and outstanding requests
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      inflight <= 3'h0;
      drop_cnt <= 3'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      inflight <= next_inflight;
      drop_cnt <= next_drop_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Local and single repeat hold
  // ----------------------------------------------------------------
  // A block longer than the queue cannot be held; software avoids it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      loop_active <= 1'b0;
      loop_base <= '0;
    end else if (branch_taken || loop_end) begin
      loop_active <= 1'b0;
    end else if (loop_begin) begin
      loop_active <= 1'b1;
      loop_base <= rd_ptr;
    end
  end

  // ----------------------------------------------------------------
  // Decode outputs
  // ----------------------------------------------------------------
  logic [15:0] next_const;
  logic [ABS_ADDR_W-1:0] next_abs;

  // Constant and absolute address sit after the opcode bytes
  assign next_const = is_ext ? {window[39:32], window[31:24]}
    : {window[23:16], window[15:8]};
  assign next_abs = {window[54:48], window[47:40], window[39:32]};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dec_valid <= 1'b0;
      dec_len <= 3'h0;
      dec_opcode <= 8'h00;
      dec_operands <= '0;
      dec_parallel <= 1'b0;
      dec_illegal <= 1'b0;
      imm_const <= 16'h0000;
      absolute_23bit_address_mode <= 1'b0;
      abs_operand_addr <= '0;
      store_imm_data <= 16'h0000;
    end else begin
      dec_valid <= consume;
      dec_len <= need_len;
      dec_opcode <= b0;
      dec_operands <= window[8*WIN_BYTES-1:8];
      dec_parallel <= consume && b0[OP_PAR_BIT];
      dec_illegal <= consume && !code_ok;
      imm_const <= next_const;
      absolute_23bit_address_mode <= consume && is_ext;
      abs_operand_addr <= is_ext ? next_abs : '0;
      store_imm_data <= next_const;
    end
  end

  // Unit strobes; illegal codes reach no unit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flow_cmd_valid <= 1'b0;
      addr_cmd_valid <= 1'b0;
      comp_cmd_valid <= 1'b0;
      store_imm_valid <= 1'b0;
    end else begin
      flow_cmd_valid <= consume && code_ok
        && (unit_sel == UNIT_FLOW);
      addr_cmd_valid <= consume && code_ok
        && (unit_sel == UNIT_ADDR);
      comp_cmd_valid <= consume && code_ok
        && (unit_sel == UNIT_COMP);
      store_imm_valid <= consume && code_ok && store_class;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      spec_fetch <= 1'b0;
      queue_fill <= '0;
    end else begin
      spec_fetch <= issue && cond_pending;
      queue_fill <= next_wr_ptr - next_rd_ptr;
    end
  end

endmodule

// ---- verilog/ifqd_pkg.sv ----
// Constants shared by the fetch queue, its decoder and its byte store.
// Assumes one core clock domain and an in-order program memory port.
package ifqd_pkg;

  // ----------------------------------------------------------------
  // Bus and queue geometry
  // ----------------------------------------------------------------
  localparam int unsigned PADDR_W = 24;
  localparam int unsigned PDATA_W = 32;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned QUEUE_BYTES = 64;
  localparam int unsigned QADDR_W = 6;
  localparam int unsigned QPTR_W = 7;
  localparam int unsigned WIN_BYTES = 7;
  localparam int unsigned MAX_INFLIGHT = 4;
  localparam logic [7:0] QUEUE_LIMIT = 8'h40;
  localparam logic [7:0] WORD_SPAN = 8'h04;
  localparam logic [2:0] INFLIGHT_MAX = 3'h4;

  // ----------------------------------------------------------------
  // Instruction lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [2:0] LEN_MIN = 3'h1;
  localparam logic [2:0] LEN_MAX = 3'h6;
  localparam logic [2:0] LEN_EXTENDABLE = 3'h4;
  localparam logic [2:0] LEN_EXTENDED = 3'h7;

  // ----------------------------------------------------------------
  // Opcode byte layout: [7:5] length-1, [4] parallel, [3:2] unit
  // ----------------------------------------------------------------
  localparam int unsigned OP_LEN_HI = 7;
  localparam int unsigned OP_LEN_LO = 5;
  localparam int unsigned OP_PAR_BIT = 4;
  localparam int unsigned OP_UNIT_HI = 3;
  localparam int unsigned OP_UNIT_LO = 2;
  localparam logic [1:0] UNIT_FLOW = 2'h0;
  localparam logic [1:0] UNIT_ADDR = 2'h1;
  localparam logic [1:0] UNIT_COMP = 2'h2;
  localparam logic [1:0] UNIT_STORE = 2'h3;

  // Second byte [7:4] selects the class of a 4-byte opcode
  localparam int unsigned CLS_HI = 7;
  localparam int unsigned CLS_LO = 4;
  localparam logic [3:0] CLS_CMP_IMM = 4'h0;
  localparam logic [3:0] CLS_BIT_TEST = 4'h1;
  localparam logic [3:0] CLS_AND_IMM = 4'h2;
  localparam logic [3:0] CLS_OR_IMM = 4'h3;
  localparam logic [3:0] CLS_XOR_IMM = 4'h4;
  localparam logic [3:0] CLS_ADD_IMM = 4'h5;
  localparam logic [3:0] CLS_MPY_K = 4'h6;
  localparam logic [3:0] CLS_MAC_K = 4'h7;
  localparam logic [3:0] CLS_ADD_SHW = 4'h8;
  localparam logic [3:0] CLS_SUB_SHW = 4'h9;
  localparam logic [3:0] CLS_LD_SHW = 4'ha;
  localparam logic [3:0] CLS_ST_HI = 4'hb;
  localparam logic [3:0] CLS_ST_HI_SAT = 4'hc;
  localparam logic [3:0] CLS_LD_MEM_IMM = 4'hd;
  // Third byte [7] marks the 23-bit absolute operand mode
  localparam int unsigned ABS23_BIT = 7;
  localparam int unsigned ABS_ADDR_W = 23;

  // ----------------------------------------------------------------
  // Fetch sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    FETCH_IDLE,
    FETCH_RUN
  } ifqd_fetch_t;

endpackage
